// ---- logic/link_setup.sv ----
`timescale 1ns/100ps
module link_setup #(
  parameter int LOCK_CYCLES = link_setup_pkg::PLL_LOCK_CYCLES,
  parameter int FRAMES_K = link_setup_pkg::FRAMES_PER_MULTIFRAME
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdio_in,
  output logic spi_sdio_out,
  output logic spi_sdio_oe,
  input wire logic sysref,
  output logic two_ddc_mode,
  output logic [4:0] decimation_ratio,
  output logic link_enabled,
  output logic pll_locked,
  output logic scramble_en,
  output logic [5:0] lane_count,
  output logic [5:0] converter_count,
  output logic [5:0] octets_per_frame,
  output logic [2:0] subclass,
  output logic ddc_a_gain_6db,
  output logic [3:0] ddc_a_ratio,
  output logic ddc_a_chan_b,
  output logic [47:0] ddc_a_tuning,
  output logic ddc_b_gain_6db,
  output logic [3:0] ddc_b_ratio,
  output logic ddc_b_chan_b,
  output logic [47:0] ddc_b_tuning,
  output logic [7:0] pll_control,
  output logic lmfc_start,
  output logic divider_resync
);
  import link_setup_pkg::*;

  function automatic logic [5:0] plus_one(input logic [4:0] code);
    plus_one = {1'b0, code} + 6'h01;
  endfunction : plus_one

  // Serial port: 16-bit instruction (read flag + address), one data byte
  logic sclk_q, sclk_rise, sclk_fall, spi_active;
  logic [4:0] bit_cnt_q;
  logic [15:0] instr_q;
  logic [7:0] wdata_q, rd_shift_q, rd_mux;
  logic is_read, wr_stb;
  logic [14:0] cur_addr, wr_addr;
  logic [7:0] wr_data;

  assign spi_active = !spi_cs_n;
  assign sclk_rise = spi_active && spi_sclk && !sclk_q;
  assign sclk_fall = spi_active && !spi_sclk && sclk_q;
  assign is_read = instr_q[15];
  assign cur_addr = {instr_q[13:0], spi_sdio_in};
  assign wr_addr = instr_q[14:0];
  assign wr_data = {wdata_q[6:0], spi_sdio_in};
  assign wr_stb = sclk_rise && !is_read && bit_cnt_q == 5'(SPI_LAST_BIT);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      bit_cnt_q <= 5'h00;
      instr_q <= 16'h0000;
      wdata_q <= 8'h00;
    end else begin
      sclk_q <= spi_sclk;
      if (!spi_active) begin
        bit_cnt_q <= 5'h00;
      end else if (sclk_rise && bit_cnt_q <= 5'(SPI_LAST_BIT)) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
        if (bit_cnt_q < 5'(SPI_INSTR_BITS)) begin
          instr_q <= {instr_q[14:0], spi_sdio_in};
        end else begin
          wdata_q <= wr_data;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_shift_q <= 8'h00;
      spi_sdio_oe <= 1'b0;
    end else begin
      if (sclk_rise && bit_cnt_q == 5'(SPI_INSTR_BITS - 1)) begin
        rd_shift_q <= rd_mux;
      end else if (sclk_fall && bit_cnt_q > 5'(SPI_INSTR_BITS)) begin
        rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      end
      spi_sdio_oe <= spi_active && is_read && bit_cnt_q >= 5'(SPI_INSTR_BITS)
                     && bit_cnt_q <= 5'(SPI_LAST_BIT);
    end
  end
  assign spi_sdio_out = rd_shift_q[7];

  // Configuration registers
  logic soft_rst;
  logic [7:0] sysref_ctrl_q, app_mode_q, chip_decim_q, pll_ctrl_q, link_power_q;
  logic [7:0] lmfc_off_q, lanes_q, octets_q, conv_q, subclass_q;
  logic [7:0] ddc_a_ctrl_q, ddc_a_ratio_q, ddc_b_ctrl_q, ddc_b_ratio_q;
  logic [7:0] init_a_q, init_b_q, init_c_q, margin_q;
  logic [7:0] tune_a_q [TUNE_BYTES];
  logic [7:0] tune_b_q [TUNE_BYTES];

  assign soft_rst = wr_stb && wr_addr == A_SOFT_RESET && wr_data == SOFT_RESET_CMD;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sysref_ctrl_q <= RST_SYSREF_CTRL;
      app_mode_q <= RST_APP_MODE;
      chip_decim_q <= RST_CHIP_DECIM;
      pll_ctrl_q <= RST_PLL_CTRL;
      link_power_q <= RST_LINK_POWER;
      lmfc_off_q <= RST_ZERO;
      lanes_q <= RST_LANES;
      octets_q <= RST_OCTETS;
      conv_q <= RST_CONVERTERS;
      subclass_q <= RST_SUBCLASS;
      ddc_a_ctrl_q <= RST_ZERO;
      ddc_a_ratio_q <= RST_ZERO;
      ddc_b_ctrl_q <= RST_ZERO;
      ddc_b_ratio_q <= RST_ZERO;
      init_a_q <= RST_ZERO;
      init_b_q <= RST_ZERO;
      init_c_q <= RST_ZERO;
      for (int i = 0; i < TUNE_BYTES; i++) begin
        tune_a_q[i] <= RST_ZERO;
        tune_b_q[i] <= RST_ZERO;
      end
    end else if (soft_rst) begin
      sysref_ctrl_q <= RST_SYSREF_CTRL;
      app_mode_q <= RST_APP_MODE;
      chip_decim_q <= RST_CHIP_DECIM;
      pll_ctrl_q <= RST_PLL_CTRL;
      link_power_q <= RST_LINK_POWER;
      lmfc_off_q <= RST_ZERO;
      lanes_q <= RST_LANES;
      octets_q <= RST_OCTETS;
      conv_q <= RST_CONVERTERS;
      subclass_q <= RST_SUBCLASS;
      ddc_a_ctrl_q <= RST_ZERO;
      ddc_a_ratio_q <= RST_ZERO;
      ddc_b_ctrl_q <= RST_ZERO;
      ddc_b_ratio_q <= RST_ZERO;
      init_a_q <= RST_ZERO;
      init_b_q <= RST_ZERO;
      init_c_q <= RST_ZERO;
      for (int i = 0; i < TUNE_BYTES; i++) begin
        tune_a_q[i] <= RST_ZERO;
        tune_b_q[i] <= RST_ZERO;
      end
    end else if (wr_stb) begin
      case (wr_addr)
        A_SYSREF_CTRL: sysref_ctrl_q <= wr_data;
        A_APP_MODE: app_mode_q <= wr_data;
        A_CHIP_DECIM: chip_decim_q <= wr_data;
        A_PLL_CTRL: pll_ctrl_q <= wr_data;
        A_LINK_POWER: link_power_q <= wr_data;
        A_LMFC_OFFSET: lmfc_off_q <= {3'h0, wr_data[4:0]};
        A_LANES: lanes_q <= wr_data;
        A_OCTETS: octets_q <= wr_data;
        A_CONVERTERS: conv_q <= wr_data;
        A_SUBCLASS: subclass_q <= wr_data;
        A_DDC_A_CTRL: ddc_a_ctrl_q <= wr_data;
        A_DDC_A_RATIO: ddc_a_ratio_q <= wr_data;
        A_DDC_B_CTRL: ddc_b_ctrl_q <= wr_data;
        A_DDC_B_RATIO: ddc_b_ratio_q <= wr_data;
        A_LANE_INIT_A: init_a_q <= wr_data;
        A_LANE_INIT_B: init_b_q <= wr_data;
        A_LANE_INIT_C: init_c_q <= wr_data;
        default: begin
          for (int i = 0; i < TUNE_BYTES; i++) begin
            if (wr_addr == A_DDC_A_TUNE + 15'(i)) begin
              tune_a_q[i] <= wr_data;
            end
            if (wr_addr == A_DDC_B_TUNE + 15'(i)) begin
              tune_b_q[i] <= wr_data;
            end
          end
        end
      endcase
    end
  end

  // Link power sequencing and lane PLL lock
  link_state_e link_state_q, link_state_d;
  logic [31:0] lock_cnt_q;
  logic lock_done;

  assign lock_done = lock_cnt_q >= 32'(LOCK_CYCLES - 1);

  always_comb begin
    link_state_d = link_state_q;
    case (link_state_q)
      LINK_DOWN: if (!link_power_q[LINK_PD_BIT]) link_state_d = LINK_LOCKING;
      LINK_LOCKING: begin
        if (link_power_q[LINK_PD_BIT]) begin
          link_state_d = LINK_DOWN;
        end else if (lock_done) begin
          link_state_d = LINK_UP;
        end
      end
      LINK_UP: if (link_power_q[LINK_PD_BIT]) link_state_d = LINK_DOWN;
      default: link_state_d = LINK_DOWN;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      link_state_q <= LINK_DOWN;
      lock_cnt_q <= 32'h0000_0000;
    end else begin
      link_state_q <= link_state_d;
      lock_cnt_q <= (link_state_q == LINK_LOCKING) ? lock_cnt_q + 32'h0000_0001
                                                   : 32'h0000_0000;
    end
  end

  logic [7:0] act_lanes_q, act_octets_q, act_conv_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      act_lanes_q <= RST_LANES;
      act_octets_q <= RST_OCTETS;
      act_conv_q <= RST_CONVERTERS;
    end else if (link_state_q == LINK_DOWN) begin
      act_lanes_q <= lanes_q;
      act_octets_q <= octets_q;
      act_conv_q <= conv_q;
    end
  end

  assign scramble_en = act_lanes_q[SCRAMBLE_BIT];
  assign lane_count = plus_one(act_lanes_q[4:0]);
  assign converter_count = plus_one(act_conv_q[4:0]);
  assign octets_per_frame = plus_one(act_octets_q[4:0]);
  assign link_enabled = link_state_q == LINK_UP;
  assign pll_locked = link_state_q == LINK_UP;
  assign pll_control = pll_ctrl_q;

  assign two_ddc_mode = app_mode_q == MODE_TWO_DDC;
  assign decimation_ratio = (chip_decim_q == DECIM_CODE_10) ? DECIM_RATIO_10 : DECIM_RATIO_1;

  assign ddc_a_gain_6db = ddc_a_ctrl_q[DDC_GAIN_BIT];
  assign ddc_b_gain_6db = ddc_b_ctrl_q[DDC_GAIN_BIT];
  assign ddc_a_ratio = (ddc_a_ctrl_q[2:0] == DDC_RATIO_FROM_INPUT) ? ddc_a_ratio_q[7:4] : 4'h0;
  assign ddc_b_ratio = (ddc_b_ctrl_q[2:0] == DDC_RATIO_FROM_INPUT) ? ddc_b_ratio_q[7:4] : 4'h0;
  assign ddc_a_chan_b = ddc_a_ratio_q[DDC_CHAN_BIT];
  assign ddc_b_chan_b = ddc_b_ratio_q[DDC_CHAN_BIT];
  assign ddc_a_tuning = {tune_a_q[5], tune_a_q[4], tune_a_q[3],
                         tune_a_q[2], tune_a_q[1], tune_a_q[0]};
  assign ddc_b_tuning = {tune_b_q[5], tune_b_q[4], tune_b_q[3],
                         tune_b_q[2], tune_b_q[1], tune_b_q[0]};

  assign subclass = subclass_q[SUBCLASS_LSB +: 3];

  // Alignment event capture on either device clock edge
  logic sr_neg_q, sr_pos_q, sr_sel, sr_sel_q, sr_event, sr_half;
  always_ff @(negedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sr_neg_q <= 1'b0;
    end else begin
      sr_neg_q <= sysref;
    end
  end

  assign sr_sel = sysref_ctrl_q[CLK_EDGE_BIT] ? sr_neg_q : sysref;
  assign sr_event = sysref_ctrl_q[SYSREF_FALL_BIT] ? (sr_sel_q && !sr_sel)
                                                   : (!sr_sel_q && sr_sel);
  assign sr_half = sr_neg_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sr_pos_q <= 1'b0;
      sr_sel_q <= 1'b0;
      margin_q <= RST_ZERO;
    end else begin
      sr_pos_q <= sysref;
      sr_sel_q <= sr_sel;
      // Clear first, so a capture in the same cycle still sets its flag
      if (soft_rst) begin
        margin_q <= RST_ZERO;
      end
      if (sysref != sr_pos_q) begin
        if (sr_half == sysref) begin
          margin_q[MARGIN_SETUP_BIT] <= 1'b1;
        end else begin
          margin_q[MARGIN_HOLD_BIT] <= 1'b1;
        end
      end
    end
  end

  logic [4:0] eff_offset;
  assign eff_offset = (act_octets_q[4:0] == 5'h00) ? {lmfc_off_q[4:2], 2'b00} :
                      (act_octets_q[4:0] == 5'h01) ? {lmfc_off_q[4:1], 1'b0} :
                      lmfc_off_q[4:0];

  // Multiframe clock, one frame per clock cycle
  logic [5:0] lmfc_cnt_q;
  logic align_now;
  assign align_now = sr_event && subclass == SUBCLASS_1;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lmfc_cnt_q <= 6'h00;
      lmfc_start <= 1'b0;
      divider_resync <= 1'b0;
    end else begin
      divider_resync <= align_now;
      if (align_now) begin
        lmfc_cnt_q <= (eff_offset == 5'h00) ? 6'h00 : 6'(FRAMES_K) - {1'b0, eff_offset};
        lmfc_start <= eff_offset == 5'h00;
      end else begin
        lmfc_cnt_q <= (lmfc_cnt_q >= 6'(FRAMES_K - 1)) ? 6'h00 : lmfc_cnt_q + 6'h01;
        lmfc_start <= lmfc_cnt_q >= 6'(FRAMES_K - 1);
      end
    end
  end

  // Read data select
  always_comb begin
    rd_mux = 8'h00;
    case (cur_addr)
      A_SYSREF_CTRL: rd_mux = sysref_ctrl_q;
      A_SYSREF_MARGIN: rd_mux = margin_q;
      A_APP_MODE: rd_mux = app_mode_q;
      A_CHIP_DECIM: rd_mux = chip_decim_q;
      A_DDC_A_CTRL: rd_mux = ddc_a_ctrl_q;
      A_DDC_A_RATIO: rd_mux = ddc_a_ratio_q;
      A_DDC_B_CTRL: rd_mux = ddc_b_ctrl_q;
      A_DDC_B_RATIO: rd_mux = ddc_b_ratio_q;
      A_PLL_CTRL: rd_mux = pll_ctrl_q;
      A_PLL_STATUS: rd_mux = {pll_locked, 7'h00};
      A_LINK_POWER: rd_mux = link_power_q;
      A_LMFC_OFFSET: rd_mux = lmfc_off_q;
      A_LANES: rd_mux = lanes_q;
      A_OCTETS: rd_mux = octets_q;
      A_CONVERTERS: rd_mux = conv_q;
      A_SUBCLASS: rd_mux = subclass_q;
      A_LANE_INIT_A: rd_mux = init_a_q;
      A_LANE_INIT_B: rd_mux = init_b_q;
      A_LANE_INIT_C: rd_mux = init_c_q;
      default: begin
        for (int i = 0; i < TUNE_BYTES; i++) begin
          if (cur_addr == A_DDC_A_TUNE + 15'(i)) rd_mux = tune_a_q[i];
          if (cur_addr == A_DDC_B_TUNE + 15'(i)) rd_mux = tune_b_q[i];
        end
      end
    endcase
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_align_no_offset;
    align_now && eff_offset == 5'h00;
  endsequence
  sequence s_write_mode_ddc;
    wr_stb && wr_addr == A_APP_MODE && wr_data == MODE_TWO_DDC;
  endsequence

  a_mode_two_ddc: assert property (s_write_mode_ddc |=> two_ddc_mode)
    else $error("two downconverter mode not selected");
  a_decim_ten: assert property (chip_decim_q == DECIM_CODE_10 |-> decimation_ratio == 5'h0A)
    else $error("decimation code 6 not ratio 10");
  a_link_params_hold: assert property (link_state_q != LINK_DOWN ##1 link_state_q != LINK_DOWN
      |-> $stable(act_lanes_q) && $stable(act_octets_q))
    else $error("link parameter changed while link up");
  a_lane_decode: assert property (act_lanes_q == 8'h87 |-> lane_count == 6'h08 && scramble_en)
    else $error("lane register decode wrong");
  a_octet_conv: assert property (act_octets_q == 8'h03 && act_conv_q == 8'h03
      |-> octets_per_frame == 6'h04 && converter_count == 6'h04)
    else $error("count minus one decode wrong");
  a_subclass_default: assert property (soft_rst |=> subclass == SUBCLASS_1)
    else $error("subclass not restored to one");
  a_lmfc_align: assert property (s_align_no_offset |=> lmfc_start && divider_resync
      ##1 !lmfc_start [*8])
    else $error("multiframe clock not aligned to event");
  a_offset_clamp: assert property (act_octets_q[4:0] == 5'h00 |-> eff_offset[1:0] == 2'b00)
    else $error("offset not clamped for one octet frames");
  a_tune_write: assert property (wr_stb && wr_addr == A_DDC_A_TUNE
      |=> ddc_a_tuning[7:0] == $past(wr_data))
    else $error("tuning byte not stored");
  a_ddc_ratio_src: assert property (ddc_a_ctrl_q == 8'h47 && ddc_a_ratio_q == 8'h20
      |-> ddc_a_gain_6db && ddc_a_ratio == DDC_RATIO_DIV10 && !ddc_a_chan_b)
    else $error("downconverter control decode wrong");
  a_no_align_sc0: assert property (subclass == SUBCLASS_0 |=> !divider_resync)
    else $error("alignment in subclass zero");
endmodule : link_setup

// ---- logic/link_setup_pkg.sv ----
// Function
// - Mode register picks full-bandwidth or two-downconverter
// - Decimation register: 0x00 is 1, 0x06 is 10
// - Link parameters change only while link powered down
// - 0x058B sets scrambling and lane count
// - Converter count stored as count minus one
// - Octets per frame stored as count minus one
// - 0x47 gives 6 dB, ratio from next register
// - Ratio nibble and input channel select register
// - Tuning word is six consecutive byte registers
// - Three-bit subclass field, default subclass one
// - Subclass zero needs no alignment event
// - Subclass one aligns multiframe clock and dividers
// - Offset delays multiframe clock in frame steps
// - Alignment event margin status is readable
// - Bit 4 selects rising or falling transition
// - Bit 3 selects device clock capture edge
package link_setup_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int PLL_LOCK_NS = 10000;
  localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAMES_PER_MULTIFRAME = 32;
  localparam int ADDR_W = 15;
  localparam int SPI_INSTR_BITS = 16;
  localparam int SPI_LAST_BIT = 23;

  localparam logic [14:0] A_SOFT_RESET = 15'h0000;
  localparam logic [14:0] A_SYSREF_CTRL = 15'h0120;
  localparam logic [14:0] A_SYSREF_MARGIN = 15'h0128;
  localparam logic [14:0] A_APP_MODE = 15'h0200;
  localparam logic [14:0] A_CHIP_DECIM = 15'h0201;
  localparam logic [14:0] A_DDC_A_CTRL = 15'h0310;
  localparam logic [14:0] A_DDC_A_RATIO = 15'h0311;
  localparam logic [14:0] A_DDC_A_TUNE = 15'h0316;
  localparam logic [14:0] A_DDC_B_CTRL = 15'h0330;
  localparam logic [14:0] A_DDC_B_RATIO = 15'h0331;
  localparam logic [14:0] A_DDC_B_TUNE = 15'h0336;
  localparam logic [14:0] A_PLL_CTRL = 15'h056E;
  localparam logic [14:0] A_PLL_STATUS = 15'h056F;
  localparam logic [14:0] A_LINK_POWER = 15'h0571;
  localparam logic [14:0] A_LMFC_OFFSET = 15'h0578;
  localparam logic [14:0] A_LANES = 15'h058B;
  localparam logic [14:0] A_OCTETS = 15'h058C;
  localparam logic [14:0] A_CONVERTERS = 15'h058E;
  localparam logic [14:0] A_SUBCLASS = 15'h0590;
  localparam logic [14:0] A_LANE_INIT_B = 15'h1222;
  localparam logic [14:0] A_LANE_INIT_A = 15'h1228;
  localparam logic [14:0] A_LANE_INIT_C = 15'h1262;
  localparam int TUNE_BYTES = 6;

  localparam logic [7:0] SOFT_RESET_CMD = 8'h81;
  localparam logic [7:0] MODE_FULL_BW = 8'h00;
  localparam logic [7:0] MODE_TWO_DDC = 8'h02;
  localparam logic [7:0] DECIM_CODE_1 = 8'h00;
  localparam logic [7:0] DECIM_CODE_10 = 8'h06;
  localparam logic [4:0] DECIM_RATIO_1 = 5'h01;
  localparam logic [4:0] DECIM_RATIO_10 = 5'h0A;
  localparam logic [7:0] LINK_POWER_DOWN = 8'h15;
  localparam logic [7:0] LINK_POWER_UP = 8'h14;
  localparam int LINK_PD_BIT = 0;
  localparam int SCRAMBLE_BIT = 7;
  localparam int DDC_GAIN_BIT = 6;
  localparam logic [2:0] DDC_RATIO_FROM_INPUT = 3'h7;
  localparam int DDC_CHAN_BIT = 0;
  localparam logic [3:0] DDC_RATIO_DIV10 = 4'h2;
  localparam int PLL_LOCK_BIT = 7;
  localparam int SUBCLASS_LSB = 5;
  localparam logic [2:0] SUBCLASS_0 = 3'h0;
  localparam logic [2:0] SUBCLASS_1 = 3'h1;
  localparam int SYSREF_FALL_BIT = 4;
  localparam int CLK_EDGE_BIT = 3;
  localparam int MARGIN_SETUP_BIT = 0;
  localparam int MARGIN_HOLD_BIT = 4;

  localparam logic [7:0] RST_SYSREF_CTRL = 8'h00;
  localparam logic [7:0] RST_APP_MODE = 8'h00;
  localparam logic [7:0] RST_CHIP_DECIM = 8'h00;
  localparam logic [7:0] RST_PLL_CTRL = 8'h00;
  localparam logic [7:0] RST_LINK_POWER = 8'h14;
  localparam logic [7:0] RST_LANES = 8'h87;
  localparam logic [7:0] RST_OCTETS = 8'h00;
  localparam logic [7:0] RST_CONVERTERS = 8'h01;
  localparam logic [7:0] RST_SUBCLASS = 8'h20;
  localparam logic [7:0] RST_ZERO = 8'h00;

  typedef enum logic [2:0] {
    LINK_DOWN = 3'b001,
    LINK_LOCKING = 3'b010,
    LINK_UP = 3'b100
  } link_state_e;
endpackage : link_setup_pkg

// ---- bench/lmfc_receiver.sv ----
`timescale 1ns/100ps
module lmfc_receiver (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic lmfc_start,
  output logic [15:0] boundary_cnt
);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      boundary_cnt <= 16'h0000;
    end else if (lmfc_start) begin
      boundary_cnt <= boundary_cnt + 16'h0001;
    end
  end
endmodule : lmfc_receiver

// ---- bench/jesd_link_setup_lmfc_alignment_test.sv ----
`timescale 1ns/100ps
module jesd_link_setup_lmfc_alignment_test;
  import link_setup_pkg::*;
  localparam int LOCK = 20;
  localparam int FK = 32;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic sdi = 1'b0;
  logic sysref = 1'b0;
  logic sdo, oe, ddc2, link_en, lock, scr, lmfc, rsy, ga, gb, ca, cb, oe_seen;
  logic [4:0] dec;
  logic [5:0] ln, cv, oc;
  logic [2:0] sub;
  logic [3:0] ra, rb;
  logic [47:0] ta, tbw, tw;
  logic [7:0] pc, q, b;
  logic [15:0] bc, b0;
  logic [7:0] m [int];
  logic [14:0] rw [18] = '{A_SYSREF_CTRL, A_APP_MODE, A_CHIP_DECIM, A_DDC_A_CTRL,
    A_DDC_A_RATIO, A_DDC_B_CTRL, A_DDC_B_RATIO, A_PLL_CTRL, A_PLL_STATUS, A_LINK_POWER,
    A_LMFC_OFFSET, A_LANES, A_OCTETS, A_CONVERTERS, A_SUBCLASS, A_LANE_INIT_A,
    A_LANE_INIT_B, A_LANE_INIT_C};
  logic [14:0] ia [7] = '{A_LANE_INIT_A, A_LANE_INIT_A, A_LANE_INIT_B, A_LANE_INIT_B,
    A_LANE_INIT_B, A_LANE_INIT_C, A_LANE_INIT_C};
  logic [7:0] id [7] = '{8'h4F, 8'h0F, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00};
  logic [7:0] pl [4] = '{8'h00, 8'h10, 8'h50, 8'h30};
  // Control, offset, octet code, expected delay
  logic [31:0] al [4] = '{32'h00000300, 32'h18030303, 32'h10060004, 32'h08050104};
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed = 32'hCE16;
  int d;

  link_setup #(.LOCK_CYCLES(LOCK), .FRAMES_K(FK)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_sdio_in(sdi), .spi_sdio_out(sdo), .spi_sdio_oe(oe), .sysref(sysref),
    .two_ddc_mode(ddc2), .decimation_ratio(dec), .link_enabled(link_en),
    .pll_locked(lock), .scramble_en(scr), .lane_count(ln), .converter_count(cv),
    .octets_per_frame(oc), .subclass(sub), .ddc_a_gain_6db(ga), .ddc_a_ratio(ra),
    .ddc_a_chan_b(ca), .ddc_a_tuning(ta), .ddc_b_gain_6db(gb), .ddc_b_ratio(rb),
    .ddc_b_chan_b(cb), .ddc_b_tuning(tbw), .pll_control(pc), .lmfc_start(lmfc),
    .divider_resync(rsy));
  lmfc_receiver rx_u (.clock(clock), .sys_rst(sys_rst), .lmfc_start(lmfc),
    .boundary_cnt(bc));

  always #2 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk_reg(input logic [14:0] a, input logic [7:0] g);
    chk($sformatf("reg %h", a), 48'(m.exists(int'(a)) ? m[int'(a)] : 8'h00), 48'(g));
  endtask : chk_reg

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Serial clock phases last two device clocks each
  task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] wd);
    logic [23:0] f;
    f = {r, a, wd};
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = f[i];
      tick(2);
      sclk = 1'b1;
      tick(2);
      if (i < 8) q[i] = sdo;
      if (i == 7) oe_seen = oe;
      sclk = 1'b0;
    end
    tick(2);
    cs_n = 1'b1;
    tick(3);
  endtask : spi

  task automatic wr(input logic [14:0] a, input logic [7:0] v);
    spi(1'b0, a, v);
    if (m.exists(int'(a)) && a != A_PLL_STATUS) m[int'(a)] = v;
  endtask : wr

  task automatic rd(input logic [14:0] a);
    spi(1'b1, a, 8'h00);
    chk_reg(a, q);
    chk("sdio_oe", 48'h1, 48'(oe_seen));
  endtask : rd

  task automatic model_reset();
    m.delete();
    foreach (rw[i]) m[int'(rw[i])] = RST_ZERO;
    for (int k = 0; k < TUNE_BYTES; k++) begin
      m[int'(A_DDC_A_TUNE) + k] = RST_ZERO;
      m[int'(A_DDC_B_TUNE) + k] = RST_ZERO;
    end
    m[int'(A_LINK_POWER)] = RST_LINK_POWER;
    m[int'(A_LANES)] = RST_LANES;
    m[int'(A_CONVERTERS)] = RST_CONVERTERS;
    m[int'(A_SUBCLASS)] = RST_SUBCLASS;
  endtask : model_reset

  task automatic link_cfg(input logic [7:0] l, mc, f, p);
    wr(A_LINK_POWER, LINK_POWER_DOWN);
    m[int'(A_PLL_STATUS)] = 8'h00;
    chk("link_enabled", 48'h0, 48'(link_en));
    wr(A_LANES, l);
    wr(A_CONVERTERS, mc);
    wr(A_OCTETS, f);
    wr(A_PLL_CTRL, p);
    wr(A_LINK_POWER, LINK_POWER_UP);
    tick(LOCK + 4);
    m[int'(A_PLL_STATUS)] = 8'h80;
    rd(A_PLL_STATUS);
    chk("pll_locked", 48'h1, 48'(lock));
    chk("link_enabled", 48'h1, 48'(link_en));
    chk("lane_count", 48'(l[4:0]) + 48'h1, 48'(ln));
    chk("scramble_en", 48'(l[7]), 48'(scr));
    chk("converter_count", 48'(mc[4:0]) + 48'h1, 48'(cv));
    chk("octets_per_frame", 48'(f[4:0]) + 48'h1, 48'(oc));
    chk("pll_control", 48'(p), 48'(pc));
  endtask : link_cfg

  task automatic align(input logic [31:0] s);
    wr(A_SYSREF_CTRL, s[31:24]);
    wr(A_LMFC_OFFSET, s[23:16]);
    sysref = s[24 + SYSREF_FALL_BIT];
    tick(4);
    sysref = ~sysref;
    d = 0;
    while (rsy !== 1'b1 && d < 6) begin
      tick(1);
      d++;
    end
    chk("divider_resync", 48'h1, 48'(rsy));
    d = 0;
    while (lmfc !== 1'b1 && d < 40) begin
      tick(1);
      d++;
    end
    chk("lmfc_delay", 48'(s[7:0]), 48'(d));
    tick(FK);
    chk("lmfc_period", 48'h1, 48'(lmfc));
  endtask : align

  initial begin
    model_reset();
    tick(2);
    sys_rst = 1'b0;
    tick(LOCK + 4);
    m[int'(A_PLL_STATUS)] = 8'h80;
    foreach (m[k]) rd(15'(k));
    rd(15'h0001);
    rd(A_SYSREF_MARGIN);
    chk("subclass", 48'(SUBCLASS_1), 48'(sub));
    $display("test reset_defaults done");
    wr(A_APP_MODE, MODE_TWO_DDC);
    wr(A_SOFT_RESET, SOFT_RESET_CMD);
    model_reset();
    rd(A_APP_MODE);
    rd(A_SOFT_RESET);
    wr(A_CHIP_DECIM, DECIM_CODE_1);
    chk("two_ddc_mode", 48'h0, 48'(ddc2));
    chk("decimation_ratio", 48'(DECIM_RATIO_1), 48'(dec));
    link_cfg(8'h87, 8'h01, 8'h00, 8'h00);
    for (int i = 0; i < 7; i++) wr(ia[i], id[i]);
    for (int i = 4; i < 7; i++) rd(ia[i]);
    wr(A_PLL_STATUS, 8'h00);
    rd(A_PLL_STATUS);
    wr(15'h0002, 8'hA5);
    rd(15'h0002);
    $display("test full_bandwidth done");
    wr(A_LANES, 8'h81);
    chk("lane_count", 48'h8, 48'(ln));
    wr(A_APP_MODE, MODE_TWO_DDC);
    wr(A_CHIP_DECIM, DECIM_CODE_10);
    chk("two_ddc_mode", 48'h1, 48'(ddc2));
    chk("decimation_ratio", 48'(DECIM_RATIO_10), 48'(dec));
    for (int k = 0; k < 2; k++) begin
      wr(k ? A_DDC_B_CTRL : A_DDC_A_CTRL, 8'h47);
      wr(k ? A_DDC_B_RATIO : A_DDC_A_RATIO, k ? 8'h25 : 8'h20);
      for (int i = 0; i < TUNE_BYTES; i++) begin
        b = 8'($random(seed));
        tw[8*i +: 8] = b;
        wr((k ? A_DDC_B_TUNE : A_DDC_A_TUNE) + 15'(i), b);
      end
      chk("ddc_gain", 48'h1, 48'(k ? gb : ga));
      chk("ddc_ratio", 48'(DDC_RATIO_DIV10), 48'(k ? rb : ra));
      chk("ddc_chan_b", 48'(k), 48'(k ? cb : ca));
      chk("ddc_tuning", tw, k ? tbw : ta);
      rd((k ? A_DDC_B_TUNE : A_DDC_A_TUNE) + 15'h5);
    end
    link_cfg(8'h81, 8'h03, 8'h03, 8'h00);
    foreach (pl[i]) begin
      wr(A_PLL_CTRL, pl[i]);
      chk("pll_control", 48'(pl[i]), 48'(pc));
    end
    $display("test two_ddc done");
    for (int i = 0; i < 4; i++) begin
      link_cfg(8'h81, 8'h03, al[i][15:8], 8'h00);
      align(al[i]);
    end
    b0 = bc;
    tick(3 * FK);
    chk("boundaries", 48'h3, 48'(bc - b0));
    spi(1'b1, A_SYSREF_MARGIN, 8'h00);
    chk("margin_flag", 48'h1, 48'((q & 8'h11) != 8'h00));
    wr(A_SUBCLASS, 8'h00);
    chk("subclass", 48'(SUBCLASS_0), 48'(sub));
    d = 0;
    for (int i = 0; i < 32; i++) begin
      if (i % 4 == 0) sysref = ~sysref;
      tick(1);
      if (rsy === 1'b1) d++;
    end
    chk("resync_count", 48'h0, 48'(d));
    wr(A_SOFT_RESET, SOFT_RESET_CMD);
    model_reset();
    rd(A_SYSREF_MARGIN);
    $display("test alignment done");
    report_and_stop();
  end
endmodule : jesd_link_setup_lmfc_alignment_test
